//--- core/misc_sfr_pkg.sv
// package: offsets, field layouts, reset values and carrier types of the misc sfr bank
// Overview of operation
// - port a pins 0-4: set bit forces pure analog
// - port b pins 1-3: set bit forces pure analog
// - route select bits steer pins to external interrupts
// - irq0/irq1 edge code: 01 rise, 10 fall, 11 both
// - timer1 upper: write reload, read live count
// - timer2 upper: write reload, read live count
// - timer3 upper: write reload, read live count
// - pwm1/pwm2 duty upper bits held in shared register
// - pwm3 duty upper bits held in timer3 register
// - comparator enable bit, resets to zero
// - pad sense enable bit, resets to zero
// - pad selector: 0-7 port a, 8-15 port b
// - factory trim loads on the first edge after reset; adjust only slow mode
// - irq2 flag set by hardware, cleared by software
// - timer3 underflow flag set by hardware, software clears
// - enable bits permit or block their interrupts
// - flag reads zero while its enable is clear
package misc_sfr_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned TRIM_W = 11;

    // register offsets
    localparam logic [ADDR_W-1:0] ANALOG_PIN_SELECT_OFS   = 8'h16;
    localparam logic [ADDR_W-1:0] EXT_IRQ_EDGE_CONFIG_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] TIMER12_PWM12_UPPER_OFS = 8'h19;
    localparam logic [ADDR_W-1:0] ANALOG_CIRCUIT_EN_OFS   = 8'h1a;
    localparam logic [ADDR_W-1:0] PAD_SENSE_CONTROL_OFS   = 8'h1b;
    localparam logic [ADDR_W-1:0] TIMER3_PWM3_UPPER_OFS   = 8'h1c;
    localparam logic [ADDR_W-1:0] OSC_TRIM_HIGH_OFS       = 8'h1d;
    localparam logic [ADDR_W-1:0] OSC_TRIM_LOW_OFS        = 8'h1e;
    localparam logic [ADDR_W-1:0] IRQ2_ENABLE_FLAG_OFS    = 8'h1f;

    // reset values
    localparam logic [DATA_W-1:0] ANALOG_PIN_SELECT_RST   = 8'h00;
    localparam logic [DATA_W-1:0] EXT_IRQ_EDGE_CONFIG_RST = 8'h05;
    localparam logic [1:0]        UPPER_BITS_RST          = 2'h0;
    localparam logic [3:0]        PAD_SEL_RST             = 4'h0;
    localparam logic [TRIM_W-1:0] TRIM_RST                = 11'h004;
    localparam logic [2:0]        TRIM_LOW_LOAD           = 3'h4;

    // field positions
    localparam int unsigned TIMER2_UPPER_LSB = 6;
    localparam int unsigned TIMER1_UPPER_LSB = 4;
    localparam int unsigned PWM2_UPPER_LSB   = 2;
    localparam int unsigned PWM1_UPPER_LSB   = 0;
    localparam int unsigned TIMER3_UPPER_LSB = 4;
    localparam int unsigned PWM3_UPPER_LSB   = 0;
    localparam int unsigned COMPARATOR_BIT   = 7;
    localparam int unsigned PAD_SENSE_BIT    = 7;
    localparam int unsigned PAD_SEL_LSB      = 0;
    localparam int unsigned TRIM_HIGH_W      = 3;
    localparam int unsigned IRQ2_FLAG_BIT    = 7;
    localparam int unsigned T3_FLAG_BIT      = 4;
    localparam int unsigned IRQ2_EN_BIT      = 3;
    localparam int unsigned T3_EN_BIT        = 0;
    localparam logic [DATA_W-1:0] IRQ2_REG_RSVD_ONES = 8'h66;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_mode_t;

    typedef struct packed {
        logic [2:0] portb_analog_only;
        logic [4:0] porta_analog_only;
    } analog_sel_t;

    typedef struct packed {
        logic       ext_irq2_edge_sel;
        logic       ext_irq2_pin_route;
        logic       ext_irq1_pin_route;
        logic       ext_irq0_pin_route;
        logic [1:0] ext_irq1_edge_sel;
        logic [1:0] ext_irq0_edge_sel;
    } ext_irq_cfg_t;

    typedef struct packed {
        logic [1:0] timer3;
        logic [1:0] timer2;
        logic [1:0] timer1;
    } upper_bits_t;

endpackage

//--- core/ext_irq_edge_detect.sv
// edge detector for one external interrupt pin, with pin synchroniser and route gate
`timescale 1ns/1ps
module ext_irq_edge_detect
    import misc_sfr_pkg::*;
(
    input  wire logic       sys_clk,    // core clock
    input  wire logic       rst_b,      // async reset, active low
    input  wire logic       pin_raw,    // asynchronous pin level
    input  wire logic       route_en,   // pin routed to the interrupt
    input  wire edge_mode_t edge_mode,  // which edges count
    output logic            edge_event  // one-cycle event pulse
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic rise;
    logic fall;
    logic hit;

    // two-flop synchroniser, clocked only while routed to save toggling
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else if (route_en) begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // history follows the synchronised level so re-routing sees no stale edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~prev_reg;
    assign fall = ~sync2_reg & prev_reg;

    // reserved code 00 detects nothing
    always_comb begin
        unique case (edge_mode)
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_BOTH: hit = rise | fall;
            EDGE_NONE: hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            edge_event <= 1'b0;
        end else begin
            edge_event <= hit & route_en;
        end
    end

endmodule

//--- core/misc_sfr_control_bank.sv
// misc special function register bank: analog pins, ext irq routing, timer/pwm upper bits, trim, irq2 flags
`timescale 1ns/1ps
module misc_sfr_control_bank (
    input  wire logic                                 sys_clk,                // core clock, 25 MHz
    input  wire logic                                 rst_b,                  // async reset, active low
    input  wire logic [misc_sfr_pkg::ADDR_W-1:0]      reg_addr,               // register address
    input  wire logic [misc_sfr_pkg::DATA_W-1:0]      reg_wdata,              // write data
    input  wire logic                                 reg_wr,                 // write strobe
    input  wire logic                                 reg_rd,                 // read strobe
    output logic      [misc_sfr_pkg::DATA_W-1:0]      reg_rdata,              // read data, cycle after strobe
    input  wire logic [7:0]                           porta_pin,              // port a pad levels, async
    input  wire logic [7:0]                           portb_pin,              // port b pad levels, async
    input  wire logic                                 ext_irq_use_porta,      // irq0/1 on port a pins
    input  wire misc_sfr_pkg::upper_bits_t            timer_live_upper,       // live count bits 9:8
    input  wire logic                                 timer3_underflow,       // timer3 underflow pulse
    input  wire logic [7:0]                           factory_trim,           // factory trim byte
    input  wire logic                                 slow_mode,              // core in slow mode
    output misc_sfr_pkg::analog_sel_t                 analog_only,            // pure analog pin select
    output misc_sfr_pkg::ext_irq_cfg_t                ext_irq_cfg,            // routing and edge config
    output misc_sfr_pkg::upper_bits_t                 timer_reload_upper,     // reload bits 9:8
    output logic      [2:0]                           timer_reload_upper_wr,  // reload upper written
    output misc_sfr_pkg::upper_bits_t                 pwm_duty_upper,         // duty bits 9:8, {3,2,1}
    output logic                                      comparator_on,          // voltage comparator enable
    output logic                                      pad_sense_on,           // pad sense enable
    output logic      [3:0]                           pad_sense_sel,          // pad selector code
    output logic      [7:0]                           pad_sense_porta,        // one-hot port a pad
    output logic      [7:0]                           pad_sense_portb,        // one-hot port b pad
    output logic      [misc_sfr_pkg::TRIM_W-1:0]      oscillator_trim,        // fast oscillator trim
    output logic                                      ext_irq0_event,         // irq0 edge pulse
    output logic                                      ext_irq1_event,         // irq1 edge pulse
    output logic                                      irq_req                 // interrupt request to core
);
    import misc_sfr_pkg::*;

    typedef enum logic [1:0] {
        TRIM_LOAD  = 2'b01,
        TRIM_READY = 2'b10
    } trim_state_t;

    analog_sel_t               analog_reg;
    ext_irq_cfg_t              edge_cfg_reg;
    upper_bits_t               reload_upper_reg;
    upper_bits_t               duty_upper_reg;
    logic [2:0]                reload_wr_reg;
    logic                      comparator_reg;
    logic                      pad_sense_on_reg;
    logic [3:0]                pad_sel_reg;
    logic [TRIM_W-1:0]         trim_reg;
    trim_state_t               trim_state_reg;
    logic                      irq2_flag_reg;
    logic                      t3_flag_reg;
    logic                      irq2_en_reg;
    logic                      t3_en_reg;
    logic [DATA_W-1:0]         rdata_reg;
    logic [DATA_W-1:0]         rdata_next;
    logic                      irq2_event;
    logic                      irq0_pin;
    logic                      irq1_pin;
    edge_mode_t                irq2_mode;

    // register hit for one strobe
    function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] ofs);
        hit = strobe && (addr == ofs);
    endfunction

    // software view of a flag: hidden while its enable is clear
    function automatic logic seen_flag(input logic flag, input logic en);
        seen_flag = flag & en;
    endfunction

    // selector code to one-hot pad on one port
    function automatic logic [7:0] pad_onehot(input logic [3:0] code, input logic want_b);
        pad_onehot = (code[3] == want_b) ? (8'h01 << code[2:0]) : 8'h00;
    endfunction

    // analog-only pin select
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            analog_reg <= analog_sel_t'(ANALOG_PIN_SELECT_RST);
        end else if (hit(reg_wr, reg_addr, ANALOG_PIN_SELECT_OFS)) begin
            analog_reg <= analog_sel_t'(reg_wdata);
        end
    end

    // interrupt routing and edge configuration
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            edge_cfg_reg <= ext_irq_cfg_t'(EXT_IRQ_EDGE_CONFIG_RST);
        end else if (hit(reg_wr, reg_addr, EXT_IRQ_EDGE_CONFIG_OFS)) begin
            edge_cfg_reg <= ext_irq_cfg_t'(reg_wdata);
        end
    end

    // timer reload upper bits; the timer consumes them on the write pulse
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reload_upper_reg <= '0;
            reload_wr_reg    <= 3'h0;
        end else begin
            reload_wr_reg <= 3'h0;
            if (hit(reg_wr, reg_addr, TIMER12_PWM12_UPPER_OFS)) begin
                reload_upper_reg.timer2 <= reg_wdata[TIMER2_UPPER_LSB +: 2];
                reload_upper_reg.timer1 <= reg_wdata[TIMER1_UPPER_LSB +: 2];
                reload_wr_reg[1:0]      <= 2'h3;
            end
            if (hit(reg_wr, reg_addr, TIMER3_PWM3_UPPER_OFS)) begin
                reload_upper_reg.timer3 <= reg_wdata[TIMER3_UPPER_LSB +: 2];
                reload_wr_reg[2]        <= 1'b1;
            end
        end
    end

    // pwm duty upper bits
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            duty_upper_reg <= '0;
        end else begin
            if (hit(reg_wr, reg_addr, TIMER12_PWM12_UPPER_OFS)) begin
                duty_upper_reg.timer2 <= reg_wdata[PWM2_UPPER_LSB +: 2];
                duty_upper_reg.timer1 <= reg_wdata[PWM1_UPPER_LSB +: 2];
            end
            if (hit(reg_wr, reg_addr, TIMER3_PWM3_UPPER_OFS)) begin
                duty_upper_reg.timer3 <= reg_wdata[PWM3_UPPER_LSB +: 2];
            end
        end
    end

    // comparator enable
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            comparator_reg <= 1'b0;
        end else if (hit(reg_wr, reg_addr, ANALOG_CIRCUIT_EN_OFS)) begin
            comparator_reg <= reg_wdata[COMPARATOR_BIT];
        end
    end

    // pad sense enable and pad selector
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pad_sense_on_reg <= 1'b0;
            pad_sel_reg      <= PAD_SEL_RST;
        end else if (hit(reg_wr, reg_addr, PAD_SENSE_CONTROL_OFS)) begin
            pad_sense_on_reg <= reg_wdata[PAD_SENSE_BIT];
            pad_sel_reg      <= reg_wdata[PAD_SEL_LSB +: 4];
        end
    end

    // trim: factory byte caught on the first edge after reset release,
    // since an async reset may only load a constant
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            trim_state_reg <= TRIM_LOAD;
            trim_reg       <= TRIM_RST;
        end else begin
            unique case (trim_state_reg)
                TRIM_LOAD: begin
                    trim_reg       <= {factory_trim, TRIM_LOW_LOAD};
                    trim_state_reg <= TRIM_READY;
                end
                TRIM_READY: begin
                    // writes outside slow mode are dropped: retuning the running clock is unsafe
                    if (slow_mode && hit(reg_wr, reg_addr, OSC_TRIM_HIGH_OFS)) begin
                        trim_reg[TRIM_W-1 -: TRIM_HIGH_W] <= reg_wdata[TRIM_HIGH_W-1:0];
                    end
                    if (slow_mode && hit(reg_wr, reg_addr, OSC_TRIM_LOW_OFS)) begin
                        trim_reg[DATA_W-1:0] <= reg_wdata;
                    end
                end
                default: begin
                    trim_state_reg <= TRIM_LOAD;
                end
            endcase
        end
    end

    // interrupt enables
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq2_en_reg <= 1'b0;
            t3_en_reg   <= 1'b0;
        end else if (hit(reg_wr, reg_addr, IRQ2_ENABLE_FLAG_OFS)) begin
            irq2_en_reg <= reg_wdata[IRQ2_EN_BIT];
            t3_en_reg   <= reg_wdata[T3_EN_BIT];
        end
    end

    // sticky flags: writing 0 clears, writing 1 is ignored, a new event beats the clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq2_flag_reg <= 1'b0;
            t3_flag_reg   <= 1'b0;
        end else begin
            if (irq2_event) begin
                irq2_flag_reg <= 1'b1;
            end else if (hit(reg_wr, reg_addr, IRQ2_ENABLE_FLAG_OFS) && !reg_wdata[IRQ2_FLAG_BIT]) begin
                irq2_flag_reg <= 1'b0;
            end
            if (timer3_underflow) begin
                t3_flag_reg <= 1'b1;
            end else if (hit(reg_wr, reg_addr, IRQ2_ENABLE_FLAG_OFS) && !reg_wdata[T3_FLAG_BIT]) begin
                t3_flag_reg <= 1'b0;
            end
        end
    end

    // pin muxing for irq0/irq1; irq2 is fixed on port a pin 5 with a rise/fall select
    assign irq0_pin  = ext_irq_use_porta ? porta_pin[4] : portb_pin[0];
    assign irq1_pin  = ext_irq_use_porta ? porta_pin[3] : portb_pin[1];
    assign irq2_mode = edge_cfg_reg.ext_irq2_edge_sel ? EDGE_RISE : EDGE_FALL;

    ext_irq_edge_detect u_irq0 (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .pin_raw    (irq0_pin),
        .route_en   (edge_cfg_reg.ext_irq0_pin_route),
        .edge_mode  (edge_mode_t'(edge_cfg_reg.ext_irq0_edge_sel)),
        .edge_event (ext_irq0_event)
    );

    ext_irq_edge_detect u_irq1 (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .pin_raw    (irq1_pin),
        .route_en   (edge_cfg_reg.ext_irq1_pin_route),
        .edge_mode  (edge_mode_t'(edge_cfg_reg.ext_irq1_edge_sel)),
        .edge_event (ext_irq1_event)
    );

    ext_irq_edge_detect u_irq2 (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .pin_raw    (porta_pin[5]),
        .route_en   (edge_cfg_reg.ext_irq2_pin_route),
        .edge_mode  (irq2_mode),
        .edge_event (irq2_event)
    );

    // read mux; timer upper fields show the live count, not the reload
    always_comb begin
        rdata_next = '0;
        unique case (reg_addr)
            ANALOG_PIN_SELECT_OFS:   rdata_next = analog_reg;
            EXT_IRQ_EDGE_CONFIG_OFS: rdata_next = edge_cfg_reg;
            TIMER12_PWM12_UPPER_OFS: rdata_next = {timer_live_upper.timer2, timer_live_upper.timer1,
                                                   duty_upper_reg.timer2, duty_upper_reg.timer1};
            ANALOG_CIRCUIT_EN_OFS:   rdata_next[COMPARATOR_BIT] = comparator_reg;
            PAD_SENSE_CONTROL_OFS:   rdata_next = {pad_sense_on_reg, 3'h0, pad_sel_reg};
            TIMER3_PWM3_UPPER_OFS:   rdata_next = {2'h0, timer_live_upper.timer3, 2'h0, duty_upper_reg.timer3};
            OSC_TRIM_HIGH_OFS:       rdata_next = {5'h00, trim_reg[TRIM_W-1 -: TRIM_HIGH_W]};
            OSC_TRIM_LOW_OFS:        rdata_next = trim_reg[DATA_W-1:0];
            IRQ2_ENABLE_FLAG_OFS: begin
                rdata_next                = IRQ2_REG_RSVD_ONES;
                rdata_next[IRQ2_FLAG_BIT] = seen_flag(irq2_flag_reg, irq2_en_reg);
                rdata_next[T3_FLAG_BIT]   = seen_flag(t3_flag_reg, t3_en_reg);
                rdata_next[IRQ2_EN_BIT]   = irq2_en_reg;
                rdata_next[T3_EN_BIT]     = t3_en_reg;
            end
            default:                 rdata_next = '0;
        endcase
    end

    // read data held one cycle after the strobe only, zero otherwise
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= reg_rd ? rdata_next : '0;
        end
    end

    assign reg_rdata             = rdata_reg;
    assign analog_only           = analog_reg;
    assign ext_irq_cfg           = edge_cfg_reg;
    assign timer_reload_upper    = reload_upper_reg;
    assign timer_reload_upper_wr = reload_wr_reg;
    assign pwm_duty_upper        = duty_upper_reg;
    assign comparator_on         = comparator_reg;
    assign pad_sense_on          = pad_sense_on_reg;
    assign pad_sense_sel         = pad_sel_reg;
    assign pad_sense_porta       = pad_onehot(pad_sel_reg, 1'b0);
    assign pad_sense_portb       = pad_onehot(pad_sel_reg, 1'b1);
    assign oscillator_trim       = trim_reg;
    // flags gated by enables; other sources of the core are combined elsewhere
    assign irq_req = seen_flag(irq2_flag_reg, irq2_en_reg) | seen_flag(t3_flag_reg, t3_en_reg);

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_flag_read_mask: assert property (
        hit(reg_rd, reg_addr, IRQ2_ENABLE_FLAG_OFS) && !irq2_en_reg && !t3_en_reg
        |=> reg_rdata[IRQ2_FLAG_BIT] == 1'b0 && reg_rdata[T3_FLAG_BIT] == 1'b0)
        else $error("flag visible while enable clear");

    a_irq2_flag_set: assert property (
        irq2_event |=> irq2_flag_reg ##1 (irq2_flag_reg || $past(reg_wr)))
        else $error("irq2 event did not set flag");

    a_t3_flag_set: assert property (
        timer3_underflow |=> t3_flag_reg)
        else $error("timer3 underflow did not set flag");

    a_irq_req_flag: assert property (
        irq_req == ((irq2_flag_reg && irq2_en_reg) || (t3_flag_reg && t3_en_reg)))
        else $error("request not matching enabled flags");

    a_trim_factory_load: assert property (
        trim_state_reg == TRIM_LOAD |=> trim_state_reg == TRIM_READY
        && oscillator_trim == {$past(factory_trim), TRIM_LOW_LOAD})
        else $error("factory trim not loaded after reset");

    a_trim_fast_locked: assert property (
        trim_state_reg == TRIM_READY && !slow_mode |=> $stable(oscillator_trim))
        else $error("trim changed outside slow mode");

    a_timer1_reload_wr: assert property (
        hit(reg_wr, reg_addr, TIMER12_PWM12_UPPER_OFS)
        |=> timer_reload_upper_wr[0] && timer_reload_upper.timer1 == $past(reg_wdata[TIMER1_UPPER_LSB +: 2])
        ##1 !timer_reload_upper_wr[0] || $past(reg_wr))
        else $error("timer1 reload upper bits not written");

    a_timer3_live_read: assert property (
        hit(reg_rd, reg_addr, TIMER3_PWM3_UPPER_OFS)
        |=> reg_rdata[TIMER3_UPPER_LSB +: 2] == $past(timer_live_upper.timer3))
        else $error("timer3 upper read not live count");

    a_irq0_route_gate: assert property (
        !$past(edge_cfg_reg.ext_irq0_pin_route) |-> !ext_irq0_event)
        else $error("irq0 event while not routed");

    a_comparator_ctl: assert property (
        hit(reg_wr, reg_addr, ANALOG_CIRCUIT_EN_OFS) |=> comparator_on == $past(reg_wdata[COMPARATOR_BIT]))
        else $error("comparator enable not following write");

endmodule

//--- tb/misc_sfr_control_bank_tb.sv
// self-checking bench for the misc sfr bank: registers, trim, pin interrupts and flags
`timescale 1ns/1ps
module misc_sfr_control_bank_tb;
    import misc_sfr_pkg::*;
    logic         sys_clk = 0, rst_b = 0, wr = 0, rd = 0, use_pa = 0, t3u = 0, slow = 0;
    logic [7:0]   addr = 0, wdata = 0, rdata, pa = 0, pb = 0, ftrim = 8'ha7, psa, psb;
    upper_bits_t  live = 0, rl, pwm;
    analog_sel_t  ana;
    ext_irq_cfg_t cfg;
    logic [2:0]   rlw;
    logic [3:0]   psel;
    logic [10:0]  trim;
    logic         cmp, pson, ev0, ev1, irq;
    int           mismatches = 0, total_checks = 0, cyc = 0, n0 = 0, n1 = 0;

    misc_sfr_control_bank u_misc_sfr_control_bank (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .porta_pin(pa), .portb_pin(pb),
        .ext_irq_use_porta(use_pa), .timer_live_upper(live), .timer3_underflow(t3u), .factory_trim(ftrim),
        .slow_mode(slow), .analog_only(ana), .ext_irq_cfg(cfg), .timer_reload_upper(rl),
        .timer_reload_upper_wr(rlw), .pwm_duty_upper(pwm), .comparator_on(cmp), .pad_sense_on(pson),
        .pad_sense_sel(psel), .pad_sense_porta(psa), .pad_sense_portb(psb), .oscillator_trim(trim),
        .ext_irq0_event(ev0), .ext_irq1_event(ev1), .irq_req(irq));

    always #20 sys_clk = ~sys_clk;
    // event counters and hang guard; the run needs about two hundred cycles, so reaching cycle 4000 means a stall
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (ev0 === 1'b1) n0 <= n0 + 1;
        if (ev1 === 1'b1) n1 <= n1 + 1;
        if (cyc == 4000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic chk(string what, logic [10:0] seen, logic [10:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle strobes; data only valid the cycle after a read strobe
    task automatic wreg(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 0;
        @(negedge sys_clk);
    endtask
    task automatic rreg(logic [7:0] a, logic [7:0] exp);
        @(posedge sys_clk);
        rd <= 1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 0;
        @(negedge sys_clk);
        chk("reg_rdata", rdata, exp);
    endtask
    task automatic t_reset;
        chk("trim", trim, {ftrim, 3'h4});
        chk("comparator_on", cmp, 0);
        rreg(8'h18, 8'h05);
        rreg(8'h1f, 8'h66);
    endtask
    task automatic t_regs;
        wreg(8'h16, 8'ha5);
        chk("analog_only", ana, 8'ha5);
        rreg(8'h16, 8'ha5);
        wreg(8'h1a, 8'h80);
        chk("comparator_on", cmp, 1);
        wreg(8'h1b, 8'h8b);
        chk("pad port b", {pson, psb}, 9'h108);
        chk("pad_sense_sel", psel, 4'hb);
        wreg(8'h1b, 8'h05);
        chk("pad port a", {pson, psa}, 9'h020);
        rreg(8'h17, 8'h00);
        @(posedge sys_clk);
        live <= 6'b10_01_10;
        wreg(8'h19, 8'h36);
        chk("reload pulse 2/1", rlw, 3'b011);
        chk("reload 2/1", {rl.timer2, rl.timer1}, 4'h3);
        chk("duty 2/1", {pwm.timer2, pwm.timer1}, 4'h6);
        rreg(8'h19, 8'h66);
        wreg(8'h1c, 8'h32);
        chk("reload pulse 3", rlw, 3'b100);
        chk("reload3 duty3", {rl.timer3, pwm.timer3}, 4'he);
        rreg(8'h1c, 8'h22);
    endtask
    task automatic t_flags;
        wreg(8'h18, 8'hc5);
        chk("ext_irq_cfg", cfg, 8'hc5);
        wreg(8'h1f, 8'h08);
        @(posedge sys_clk);
        pa <= 8'h20;
        repeat (8) @(posedge sys_clk);
        rreg(8'h1f, 8'hee);
        chk("irq_req", irq, 1);
        wreg(8'h1f, 8'h08);
        rreg(8'h1f, 8'h6e);
        wreg(8'h1f, 8'h00);
        @(posedge sys_clk);
        t3u <= 1;
        @(posedge sys_clk);
        t3u <= 0;
        rreg(8'h1f, 8'h66);
        chk("irq_req", irq, 0);
        // a one on the flag bit leaves the pending flag alone
        wreg(8'h1f, 8'h11);
        rreg(8'h1f, 8'h77);
        chk("irq_req", irq, 1);
    endtask
    // per config: both routed pins pulse once, twice in the both-edges row; reserved code and unrouted rows see none;
    // last row toggles only port b, so a wrong pin mux shows as missing events
    task automatic t_edges;
        logic [7:0] cf [6] = '{8'h35, 8'h3a, 8'h3f, 8'h30, 8'h0f, 8'h35};
        int ex [6] = '{1, 1, 2, 0, 0, 1};
        int b0;
        int b1;
        foreach (cf[i]) begin
            @(posedge sys_clk);
            use_pa <= (i < 5);
            wreg(8'h18, cf[i]);
            b0 = n0;
            b1 = n1;
            @(posedge sys_clk);
            if (i < 5) pa[4:3] <= 2'b11;
            else pb[1:0] <= 2'b11;
            repeat (8) @(posedge sys_clk);
            pa[4:3] <= 2'b00;
            pb[1:0] <= 2'b00;
            repeat (8) @(posedge sys_clk);
            chk("irq0 events", n0 - b0, ex[i]);
            chk("irq1 events", n1 - b1, ex[i]);
        end
    endtask
    task automatic t_trim;
        slow <= 1;
        wreg(8'h1d, 8'h02);
        wreg(8'h1e, 8'h5a);
        chk("trim", trim, 11'h25a);
        @(posedge sys_clk);
        slow <= 0;
        wreg(8'h1e, 8'hff);
        chk("trim", trim, 11'h25a);
    endtask
    task automatic stop_test;
        $display("mismatches %0d total_checks %0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1;
        repeat (2) @(negedge sys_clk);
        t_reset();
        t_regs();
        t_flags();
        t_edges();
        t_trim();
        stop_test();
    end
endmodule
